// ==== hdl/spcs_pkg.sv ====
// Behaviour
// [RL1] Transmit clock out at ref rate or double
// [RL2] Full rate: true/complement clocks, data on rise
// [RL3] Half rate: clocks at half rate, both edges
// [RL4] Self-test status on data bits 1:0
// [RL5] Self-test flag valid only when control is 10
// [RL6] Powered-down flag high when both reclock enables off
// [RL7] Half-rate transmit inputs sampled on both edges
// [RL8] Half-rate transmit status on both edges
// [RL9] Recovered clock runs continuously at selected rate; code moves it only on characters
// [RL10] Host decodes flag plus bits 1:0 jointly
package spcs_pkg;
  localparam int DATA_W = 10;
  localparam int STAT_W = 2;
  localparam logic [1:0] SELFTEST_REPORT = 2'h2;
  localparam logic [1:0] SELFTEST_OFF = 2'h0;
  localparam logic [STAT_W-1:0] STAT_IDLE = 2'h0;
  localparam logic [STAT_W-1:0] STAT_PASS = 2'h1;
  localparam logic [STAT_W-1:0] STAT_ERR = 2'h2;
  localparam logic [STAT_W-1:0] STAT_RUN = 2'h3;
  localparam logic [8:0] PATTERN_LEN = 9'h1FF;
  localparam logic [8:0] PATTERN_SEED = 9'h1FF;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h1;
  localparam logic [3:0] REG_STATE = 4'h2;
  localparam int REF_CNT_W = 8;
  localparam logic [REF_CNT_W-1:0] REF_CNT_MAX = 8'hFF;
  localparam logic [REF_CNT_W-1:0] REF_CNT_STEP = 8'h01;
  typedef enum logic [1:0] {
    SPCS_RX_LOW = 2'b00,
    SPCS_RX_HIGH = 2'b01
  } spcs_phase_type;
endpackage

// ==== hdl/spcs_edge_sync.sv ====
`timescale 1ns/1ps
module spcs_edge_sync (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end
  assign level = sync_reg;
  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;
endmodule

// ==== hdl/spcs_top.sv ====
`timescale 1ns/1ps
module spcs_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic tx_reference_clock,
  input wire logic tx_rate_select,
  input wire logic tx_half_rate,
  input wire logic [spcs_pkg::DATA_W-1:0] tx_parallel_data,
  input wire logic tx_event,
  input wire logic rx_char_strobe,
  input wire logic [spcs_pkg::DATA_W-1:0] rx_char_data,
  input wire logic rx_rate_select,
  input wire logic [1:0] rx_selftest_control,
  input wire logic reclock_out1_enable,
  input wire logic reclock_out2_enable,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic irq,
  output logic tx_clock_out,
  output logic [spcs_pkg::DATA_W-1:0] tx_captured_data,
  output logic tx_status,
  output logic rx_recovered_clock,
  output logic rx_recovered_clock_n,
  output logic [spcs_pkg::DATA_W-1:0] rx_parallel_data,
  output logic rx_selftest_flag,
  output logic reclock_powered_down
);
  logic ref_level;
  logic ref_rise;
  logic ref_fall;
  logic [spcs_pkg::DATA_W-1:0] txd_meta_reg;
  logic [spcs_pkg::DATA_W-1:0] txd_sync_reg;
  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  logic txr_s;
  logic txh_s;
  logic txe_s;
  logic rxr_s;
  logic rxs_s;
  logic [1:0] ctl_meta_reg;
  logic [1:0] ctl_sync_reg;
  logic [spcs_pkg::DATA_W-1:0] rxc_meta_reg;
  logic [spcs_pkg::DATA_W-1:0] rxc_sync_reg;
  logic [1:0] roe_meta_reg;
  logic [1:0] roe_sync_reg;
  logic rxs_last_reg;
  logic char_take;
  logic tx_edge;
  logic rx_half_reg;
  spcs_pkg::spcs_phase_type rx_phase_reg;
  logic [8:0] lfsr_reg;
  logic [8:0] lfsr_next;
  logic [8:0] bist_cnt_reg;
  logic bist_err_reg;
  logic [spcs_pkg::STAT_W-1:0] bist_stat_next;
  logic [2:0] status_reg;
  logic [2:0] mask_reg;
  logic [2:0] event_set;
  logic pd_last_reg;
  logic [spcs_pkg::REF_CNT_W-1:0] ref_cnt_reg;
  logic [spcs_pkg::REF_CNT_W-1:0] ref_span_reg;

  spcs_edge_sync u_ref_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in(tx_reference_clock),
    .level(ref_level),
    .rise(ref_rise),
    .fall(ref_fall)
  );

  // Two-stage synchronisers for every pin input except the register bus
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      txd_meta_reg <= '0;
      txd_sync_reg <= '0;
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      ctl_meta_reg <= '0;
      ctl_sync_reg <= '0;
      rxc_meta_reg <= '0;
      rxc_sync_reg <= '0;
      // Enables idle high; zero would fake a power-down entry
      roe_meta_reg <= '1;
      roe_sync_reg <= '1;
    end else begin
      txd_meta_reg <= tx_parallel_data;
      txd_sync_reg <= txd_meta_reg;
      pin_meta_reg <= {tx_rate_select, tx_half_rate, tx_event,
                       rx_rate_select, rx_char_strobe};
      pin_sync_reg <= pin_meta_reg;
      ctl_meta_reg <= rx_selftest_control;
      ctl_sync_reg <= ctl_meta_reg;
      rxc_meta_reg <= rx_char_data;
      rxc_sync_reg <= rxc_meta_reg;
      roe_meta_reg <= {reclock_out2_enable, reclock_out1_enable};
      roe_sync_reg <= roe_meta_reg;
    end
  end
  assign txr_s = pin_sync_reg[4];
  assign txh_s = pin_sync_reg[3];
  assign txe_s = pin_sync_reg[2];
  assign rxr_s = pin_sync_reg[1];
  assign rxs_s = pin_sync_reg[0];

  // Reference half period less one, in sys_clk cycles, measured continuously
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ref_cnt_reg <= '0;
      ref_span_reg <= '0;
    end else if (ref_rise | ref_fall) begin
      ref_cnt_reg <= '0;
      ref_span_reg <= ref_cnt_reg;
    end else if (ref_cnt_reg != spcs_pkg::REF_CNT_MAX) begin
      ref_cnt_reg <= ref_cnt_reg + spcs_pkg::REF_CNT_STEP;
    end
  end

  // Doubled clock: one pulse per reference edge, low at mid span.
  // Only as fine as sys_clk, so duty is uneven for even spans.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tx_clock_out <= 1'b0;
    end else if (txr_s) begin
      if (ref_rise | ref_fall) begin
        tx_clock_out <= 1'b1; // [RL1]
      end else if (ref_cnt_reg == (ref_span_reg >> 1)) begin
        tx_clock_out <= 1'b0; // [RL1]
      end
    end else begin
      tx_clock_out <= ref_level; // [RL1]
    end
  end

  // Half-rate: capture and status change on both reference edges
  assign tx_edge = txh_s ? (ref_rise | ref_fall) : ref_rise; // [RL7]
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tx_captured_data <= '0;
      tx_status <= 1'b0;
    end else if (tx_edge) begin
      tx_captured_data <= txd_sync_reg; // [RL7]
      tx_status <= txe_s; // [RL8]
    end
  end

  // Recovered clock: one toggle per character in half rate,
  // a full period per character in full rate.
  assign char_take = rxs_s & ~rxs_last_reg;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rxs_last_reg <= 1'b0;
      rx_half_reg <= 1'b0;
      rx_phase_reg <= spcs_pkg::SPCS_RX_LOW;
      rx_recovered_clock <= 1'b0;
      rx_recovered_clock_n <= 1'b1;
    end else begin
      rxs_last_reg <= rxs_s;
      if (char_take) begin
        rx_half_reg <= ~rxr_s;
      end
      unique case (rx_phase_reg)
        spcs_pkg::SPCS_RX_LOW: begin
          if (char_take) begin
            rx_phase_reg <= spcs_pkg::SPCS_RX_HIGH; // [RL9]
            rx_recovered_clock <= 1'b1; // [RL2] [RL3]
            rx_recovered_clock_n <= 1'b0;
          end
        end
        spcs_pkg::SPCS_RX_HIGH: begin
          // Full rate drops mid-character; half rate waits a char
          if (rx_half_reg ? char_take : ~rxs_s) begin
            rx_phase_reg <= spcs_pkg::SPCS_RX_LOW; // [RL9]
            rx_recovered_clock <= 1'b0; // [RL2] [RL3]
            rx_recovered_clock_n <= 1'b1;
          end
        end
        default: begin
          // Stray code: park low rather than hang the clock
          rx_phase_reg <= spcs_pkg::SPCS_RX_LOW;
          rx_recovered_clock <= 1'b0;
          rx_recovered_clock_n <= 1'b1;
        end
      endcase
    end
  end

  // Self-test receiver: 9-bit pattern check over the low bits
  assign lfsr_next = {lfsr_reg[7:0], lfsr_reg[8] ^ lfsr_reg[4]};
  always_comb begin
    bist_stat_next = spcs_pkg::STAT_RUN;
    if (bist_err_reg) begin
      bist_stat_next = spcs_pkg::STAT_ERR;
    end else if (bist_cnt_reg == spcs_pkg::PATTERN_LEN) begin
      bist_stat_next = spcs_pkg::STAT_PASS;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      lfsr_reg <= spcs_pkg::PATTERN_SEED;
      bist_cnt_reg <= '0;
      bist_err_reg <= 1'b0;
    end else if (ctl_sync_reg == spcs_pkg::SELFTEST_OFF) begin
      lfsr_reg <= spcs_pkg::PATTERN_SEED;
      bist_cnt_reg <= '0;
      bist_err_reg <= 1'b0;
    end else if (char_take) begin
      lfsr_reg <= lfsr_next;
      bist_cnt_reg <= (bist_cnt_reg == spcs_pkg::PATTERN_LEN) ?
                      9'h000 : bist_cnt_reg + 9'h001;
      if (rxc_sync_reg[8:0] != lfsr_reg) begin
        bist_err_reg <= 1'b1;
      end
    end
  end

  // Data updates only with the character, so it follows clock edges
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rx_parallel_data <= '0;
      rx_selftest_flag <= 1'b0;
    end else if (char_take) begin
      if (ctl_sync_reg != spcs_pkg::SELFTEST_OFF) begin
        // Upper bits left as received; host ignores them
        rx_parallel_data <= {rxc_sync_reg[9:2], bist_stat_next}; // [RL4]
        rx_selftest_flag <= (ctl_sync_reg == spcs_pkg::SELFTEST_REPORT)
                            & bist_err_reg; // [RL5] [RL10]
      end else begin
        rx_parallel_data <= rxc_sync_reg; // [RL2] [RL3]
        rx_selftest_flag <= 1'b0; // [RL5]
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reclock_powered_down <= 1'b0;
      pd_last_reg <= 1'b0;
    end else begin
      reclock_powered_down <= (roe_sync_reg == 2'h0); // [RL6]
      pd_last_reg <= reclock_powered_down;
    end
  end

  // Events: powered-down entry, self-test error, self-test pass
  assign event_set = {reclock_powered_down & ~pd_last_reg,
                      char_take & bist_err_reg,
                      char_take & (bist_stat_next == spcs_pkg::STAT_PASS)
                      & (ctl_sync_reg != spcs_pkg::SELFTEST_OFF)};

  // Mask only gates irq; status keeps latching
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mask_reg <= '0;
    end else if (reg_wr && reg_addr == spcs_pkg::REG_MASK) begin
      mask_reg <= reg_wdata[2:0];
    end
  end

  // Set beats a same-cycle write-one clear
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      status_reg <= '0;
    end else if (reg_wr && reg_addr == spcs_pkg::REG_STATUS) begin
      status_reg <= (status_reg & ~reg_wdata[2:0]) | event_set;
    end else begin
      status_reg <= status_reg | event_set;
    end
  end

  // Level interrupt, registered so the pin never glitches
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // Zero outside the answer cycle so stale reads never linger
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        spcs_pkg::REG_STATUS: reg_rdata <= {13'h0000, status_reg};
        spcs_pkg::REG_MASK: reg_rdata <= {13'h0000, mask_reg};
        spcs_pkg::REG_STATE: begin
          reg_rdata <= {11'h000, bist_err_reg, reclock_powered_down,
                        rx_half_reg, tx_clock_out, txr_s};
        end
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule

// ==== bench/spcs_chk.sv ====
`timescale 1ns/1ps
module spcs_chk (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic tx_reference_clock,
  input wire logic tx_rate_select,
  input wire logic rx_rate_select,
  input wire logic [1:0] rx_selftest_control,
  input wire logic reclock_out1_enable,
  input wire logic reclock_out2_enable,
  input wire logic [15:0] reg_rdata,
  input wire logic irq,
  input wire logic tx_clock_out,
  input wire logic rx_recovered_clock,
  input wire logic rx_recovered_clock_n,
  input wire logic [spcs_pkg::DATA_W-1:0] rx_parallel_data,
  input wire logic rx_selftest_flag,
  input wire logic reclock_powered_down
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic off;
  assign off = !reclock_out1_enable && !reclock_out2_enable;
  AST_PD_ON:
    assert property (off [*4] |-> reclock_powered_down)
    else $error("pd flag not raised");
  AST_PD_OFF:
    assert property (!off [*4] |-> !reclock_powered_down)
    else $error("pd flag not dropped");
  AST_CLK_PAIR:
    assert property (rx_recovered_clock_n == !rx_recovered_clock)
    else $error("rx clocks not complementary");
  AST_DATA_EDGE:
    assert property ($changed(rx_parallel_data) |->
      $changed(rx_recovered_clock)) else $error("data off clock edge");
  AST_FULL_RISE:
    assert property (rx_rate_select [*8] ##0 $fell(rx_recovered_clock)
      |-> $stable(rx_parallel_data)) else $error("data on falling edge");
  AST_FLAG:
    assert property ($rose(rx_selftest_flag) |->
      $past(rx_selftest_control, 3) == 2'h2)
    else $error("flag outside report mode");
  AST_TX_FOLLOW:
    assert property (!tx_rate_select [*8] |-> tx_clock_out ==
      $past(tx_reference_clock, 3) || tx_clock_out ==
      $past(tx_reference_clock, 4) || tx_clock_out ==
      $past(tx_reference_clock, 5)) else $error("tx clock not following");
  // Sync reset must clear outputs even while disabled elsewhere
  AST_RST:
    assert property (disable iff (1'b0) !rstn |=> !irq &&
      rx_recovered_clock_n && reg_rdata == 16'h0)
    else $error("outputs not reset");
  cover property (reclock_powered_down);
  cover property ($rose(rx_selftest_flag));
  cover property (tx_rate_select && $changed(tx_clock_out));
endmodule
bind spcs_top spcs_chk chk (.*);

// ==== bench/spcs_host.sv ====
`timescale 1ns/1ps
module spcs_host (
  input wire logic sys_clk,
  input wire logic clk_in,
  input wire logic full,
  input wire logic [spcs_pkg::DATA_W-1:0] data,
  input wire logic flag,
  input wire logic [1:0] ctrl,
  output logic got,
  output logic [spcs_pkg::DATA_W-1:0] word,
  output logic [2:0] code
);
  logic prev;
  // Full rate takes rising edges only, half rate both
  always @(posedge sys_clk) begin
    prev <= clk_in;
    got <= clk_in != prev && (clk_in || !full);
    word <= data;
    code <= {flag && ctrl == 2'h2, data[1:0]};
  end
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 0, rstn = 0, tx_reference_clock = 0, tx_rate_select = 0;
  logic tx_half_rate = 0, tx_event = 0, rx_char_strobe = 0;
  logic rx_rate_select = 1, reg_wr = 0, reg_rd = 0, rd_d = 0, st = 0;
  logic reclock_out1_enable = 1, reclock_out2_enable = 1, last = 0;
  logic [spcs_pkg::DATA_W-1:0] tx_parallel_data = 0, rx_char_data = 0;
  logic [1:0] rx_selftest_control = 0;
  logic [3:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, r, e;
  logic irq, tx_clock_out, tx_status, rx_recovered_clock;
  logic rx_recovered_clock_n, rx_selftest_flag, reclock_powered_down, got;
  logic [spcs_pkg::DATA_W-1:0] tx_captured_data, rx_parallel_data, word;
  logic [2:0] code;
  logic [15:0] q_char[$], q_reg[$];
  int n_fail = 0, comparisons = 0, cnt;
  spcs_top dut (.*);
  spcs_host host (.sys_clk(sys_clk), .clk_in(rx_recovered_clock),
    .full(rx_rate_select), .data(rx_parallel_data),
    .flag(rx_selftest_flag), .ctrl(rx_selftest_control), .got(got),
    .word(word), .code(code));
  always #20 sys_clk = ~sys_clk;
  initial begin
    #13;
    forever #160 tx_reference_clock = ~tx_reference_clock;
  end
  task automatic chk(string n, logic [15:0] x, logic [15:0] g);
    comparisons++;
    if (g !== x) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick();
    reg_wr <= 1'b0;
    tick();
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] x);
    q_reg.push_back(x);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick();
    reg_rd <= 1'b0;
    tick();
  endtask
  task automatic send(logic [9:0] d, logic [15:0] x);
    q_char.push_back(x);
    rx_char_data <= d;
    rx_char_strobe <= 1'b1;
    tick(4);
    rx_char_strobe <= 1'b0;
    tick(4);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    if (rd_d) chk("rdata", q_reg.pop_front(), reg_rdata);
    if (got === 1'b1) begin
      if (q_char.size() == 0) begin
        n_fail++;
        $display("Error char expected none seen %h", word);
      end else begin
        e = q_char.pop_front();
        chk(st ? "code" : "char", e, st ? code : word);
      end
    end
  end
  initial begin
    tick(20000);
    n_fail++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hC2D2D696));
    tick(12);
    rstn <= 1'b1;
    tick(3);
    for (int m = 0; m < 2; m++) begin
      rx_rate_select <= !m;
      tick(8);
      repeat (8) begin
        r = 16'($urandom) & 16'h03FF;
        send(r[9:0], r);
      end
    end
    rx_rate_select <= 1'b1;
    rx_selftest_control <= 2'h2;
    st <= 1'b1;
    tick(8);
    send(10'h000, 16'h0003);
    send(10'h000, 16'h0006);
    rx_selftest_control <= 2'h1;
    send(10'h000, 16'h0002);
    st <= 1'b0;
    rd(4'h0, 16'h0002);
    chk("irq", 16'h0, irq);
    wr(4'h1, 16'h0002);
    tick(2);
    chk("irq", 16'h1, irq);
    rd(4'h1, 16'h0002);
    rd(4'hF, 16'h0000);
    rx_selftest_control <= 2'h0;
    tick(2);
    wr(4'h0, 16'h0007);
    tick(2);
    chk("irq", 16'h0, irq);
    rd(4'h0, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      {reclock_out1_enable, reclock_out2_enable} <= 2'(k);
      tick(6);
      chk("pd", 16'(k == 0), reclock_powered_down);
    end
    rd(4'h0, 16'h0004);
    wr(4'h1, 16'h0004);
    tick(2);
    chk("irq", 16'h1, irq);
    wr(4'h0, 16'h0004);
    tick(2);
    chk("irq", 16'h0, irq);
    for (int m = 0; m < 2; m++) begin
      tx_rate_select <= m[0];
      tx_half_rate <= m[0];
      tick(8);
      cnt = 0;
      repeat (64) begin
        tick();
        cnt += int'(tx_clock_out !== last);
        last = tx_clock_out;
      end
      r = 16'(cnt >= (16 << m) - 1 && cnt <= (16 << m) + 1);
      chk("txclk", 16'h1, r);
      @(negedge tx_reference_clock);
      tick();
      tx_parallel_data <= 10'h155;
      tx_event <= 1'b0;
      tick(16);
      // Rising edge just passed: only a falling capture can show it
      @(posedge tx_reference_clock);
      tick();
      tx_parallel_data <= 10'h2AA;
      tx_event <= 1'b1;
      tick(7);
      chk("txdata", m ? 16'h02AA : 16'h0155, tx_captured_data);
      chk("txstat", 16'(m), tx_status);
    end
    chk("pending", 16'h0, 16'(q_char.size() + q_reg.size()));
    give_verdict();
  end
endmodule
